// ---- oled_cmd_params.svh ----
`ifndef OLED_CMD_PARAMS_SVH
`define OLED_CMD_PARAMS_SVH
`define CMD_CONTRAST_MODE 8'h81
`define CMD_SEG_REMAP 7'h50
`define CMD_ENTIRE_ON 7'h52
`define CMD_MUX_MODE 8'ha8
`define CMD_DCDC_MODE 8'had
`define CMD_DCDC_DATA 7'h45
`define CMD_DISPLAY 7'h57
`define CMD_PAGE 5'h16
`define CMD_COM_SCAN 4'hc
`define CMD_INVERT 7'h53
`define CMD_COL_LOW 4'h0
`define CMD_COL_HIGH 4'h1
`define RST_CONTRAST 8'h80
`define RST_MUX_RATIO 7'h40
`define CMD_FLAG_BIT 0
`define CMD_SCAN_BIT 3
`define RST_DCDC 1'b1
`define COL_LAST 8'h83
`endif

// ---- oled_cmd_pkg.sv ----
package oled_cmd_pkg;
  // Decoder phase: which byte the next command byte is taken as
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CONTRAST = 2'b01,
    PH_MUX = 2'b11,
    PH_DCDC = 2'b10
  } phase_e;
endpackage

// ---- oled_panel_command_decoder.sv ----
// Notes on behaviour
// RL1: 81H arms contrast; next byte is value
// RL2: Armed byte is contrast only; then disarm
// RL3: Contrast is full 8 bits, 256 levels
// RL4: Host leaves contrast at 80H if unused
// RL5: Reset loads contrast with 80H
// RL6: A0H/A1H bit 0 sets segment reverse
// RL7: Data access bumps column by one
// RL8: A4H/A5H forces all pixels on, RAM kept
// RL9: A5H forces on, A4H normal; reset normal
// RL10: Entire-on overrides inversion setting
// RL11: A8H then byte; low six bits used
// RL12: Mux ratio is value plus one; reset 64
// RL13: ADH then 8AH/8BH; bit 0 enables converter
// RL14: Converter runs only if enabled and on
// RL15: Host turns display off before DC-DC setup
// RL16: Off means sleep; on picks supply source
// RL17: AEH/AFH bit 0 sets display on
// RL18: Sleep stops oscillator, converter; outputs hi-Z
// RL19: Sleep keeps settings and RAM access
// RL20: B0H-B7H loads page address bits
// RL21: C0H-C8H bit 3 sets common scan reverse
// RL22: Host sends only defined command codes
// RL23: Select low marks command; track sequences
`timescale 1ns/1ps
`include "oled_cmd_params.svh"
module oled_panel_command_decoder
  import oled_cmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic command_data_select,
  input wire logic ram_access,
  output logic [7:0] contrast,
  output logic segment_reverse,
  output logic entire_on,
  output logic invert,
  output logic [6:0] mux_ratio,
  output logic dcdc_enable,
  output logic display_on,
  output logic sleep,
  output logic dcdc_run,
  output logic external_supply,
  output logic oscillator_run,
  output logic outputs_hiz,
  output logic force_pixels,
  output logic [2:0] page_address,
  output logic [7:0] column_address,
  output logic com_reverse,
  output logic contrast_armed
);
  // Slot of each mode flag in the flag vector
  localparam int FLAG_REMAP = 0;
  localparam int FLAG_ENTIRE = 1;
  localparam int FLAG_INVERT = 2;
  localparam int FLAG_DISPLAY = 3;
  localparam int FLAG_SCAN = 4;
  localparam int FLAG_COUNT = 5;

  // Sequence phase: meaning of the next command byte
  phase_e phase_reg, phase_next;
  // Stored settings with their next values
  logic [7:0] contrast_reg, contrast_next;
  logic [6:0] mux_ratio_reg, mux_ratio_next;
  logic dcdc_reg, dcdc_next;
  logic [2:0] page_reg, page_next;
  logic [7:0] col_reg, col_next;
  // Mode flags are nets, since each bit has its own driver
  wire logic [FLAG_COUNT-1:0] flag_reg;
  wire logic [FLAG_COUNT-1:0] flag_next;
  wire logic [FLAG_COUNT-1:0] flag_hit;
  wire logic [FLAG_COUNT-1:0] flag_bit;
  // Power and pixel outputs kept in flip-flops
  logic sleep_reg, sleep_next;
  logic dcdc_run_reg, dcdc_run_next;
  logic ext_supply_reg, ext_supply_next;
  logic force_reg, force_next;
  // Decoded strobes for the byte on the inputs
  logic is_cmd;
  logic is_opcode;
  logic hit_contrast_mode;
  logic hit_mux_mode;
  logic hit_dcdc_mode;
  logic hit_page;
  logic hit_col_low;
  logic hit_col_high;
  logic take_contrast;
  logic take_mux;
  logic take_dcdc;

  // Byte with select low is a command byte
  assign is_cmd = byte_valid && !command_data_select; // RL23
  // Outside a sequence a command byte is an opcode
  assign is_opcode = is_cmd && (phase_reg == PH_IDLE); // RL23
  // Inside a sequence it is a value, whatever its code
  assign take_contrast = is_cmd && (phase_reg == PH_CONTRAST); // RL2
  assign take_mux = is_cmd && (phase_reg == PH_MUX); // RL11
  assign take_dcdc = is_cmd && (phase_reg == PH_DCDC); // RL13

  // Opcode decode; codes are disjoint, so no priority
  assign hit_contrast_mode = is_opcode && (byte_data == `CMD_CONTRAST_MODE); // RL1
  assign hit_mux_mode = is_opcode && (byte_data == `CMD_MUX_MODE); // RL11
  assign hit_dcdc_mode = is_opcode && (byte_data == `CMD_DCDC_MODE); // RL13
  assign hit_page = is_opcode && (byte_data[7:3] == `CMD_PAGE); // RL20
  assign hit_col_low = is_opcode && (byte_data[7:4] == `CMD_COL_LOW);
  assign hit_col_high = is_opcode && (byte_data[7:4] == `CMD_COL_HIGH);

  // Flag strobes and the command bit each one copies
  assign flag_hit[FLAG_REMAP] = is_opcode && (byte_data[7:1] == `CMD_SEG_REMAP); // RL6
  assign flag_hit[FLAG_ENTIRE] = is_opcode && (byte_data[7:1] == `CMD_ENTIRE_ON); // RL8 RL9
  assign flag_hit[FLAG_INVERT] = is_opcode && (byte_data[7:1] == `CMD_INVERT);
  assign flag_hit[FLAG_DISPLAY] = is_opcode && (byte_data[7:1] == `CMD_DISPLAY); // RL17
  assign flag_hit[FLAG_SCAN] = is_opcode && (byte_data[7:4] == `CMD_COM_SCAN); // RL21
  assign flag_bit[FLAG_REMAP] = byte_data[`CMD_FLAG_BIT]; // RL6
  assign flag_bit[FLAG_ENTIRE] = byte_data[`CMD_FLAG_BIT]; // RL9
  assign flag_bit[FLAG_INVERT] = byte_data[`CMD_FLAG_BIT];
  assign flag_bit[FLAG_DISPLAY] = byte_data[`CMD_FLAG_BIT]; // RL17
  assign flag_bit[FLAG_SCAN] = byte_data[`CMD_SCAN_BIT]; // RL21

  // Phase: armed by a mode byte, idle after the value
  always_comb begin
    phase_next = phase_reg;
    if (hit_contrast_mode) begin
      phase_next = PH_CONTRAST; // RL1
    end else if (hit_mux_mode) begin
      phase_next = PH_MUX; // RL11
    end else if (hit_dcdc_mode) begin
      phase_next = PH_DCDC; // RL13
    end else if (take_contrast || take_mux || take_dcdc) begin
      phase_next = PH_IDLE; // RL2
    end
  end
  // Phase flop; a reset mid-sequence drops the sequence
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Contrast: whole byte taken, so all 256 levels reachable
  always_comb begin
    contrast_next = contrast_reg;
    if (take_contrast) begin
      contrast_next = byte_data; // RL2 RL3
    end
  end
  // Reset lands on the midpoint level
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      contrast_reg <= `RST_CONTRAST; // RL5
    end else begin
      contrast_reg <= contrast_next;
    end
  end

  // Ratio stored already incremented, so the output is a flop
  always_comb begin
    mux_ratio_next = mux_ratio_reg;
    if (take_mux) begin
      mux_ratio_next = {1'b0, byte_data[5:0]} + 7'h01; // RL11 RL12
    end
  end
  // Full 64-line ratio after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mux_ratio_reg <= `RST_MUX_RATIO; // RL12
    end else begin
      mux_ratio_reg <= mux_ratio_next;
    end
  end

  // Converter flag; a stray second byte only ends the sequence
  always_comb begin
    dcdc_next = dcdc_reg;
    if (take_dcdc && (byte_data[7:1] == `CMD_DCDC_DATA)) begin
      dcdc_next = byte_data[`CMD_FLAG_BIT]; // RL13
    end
  end
  // Internal converter selected after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dcdc_reg <= `RST_DCDC; // RL14
    end else begin
      dcdc_reg <= dcdc_next;
    end
  end

  // Page selects RAM only; the shown image is untouched
  always_comb begin
    page_next = page_reg;
    if (hit_page) begin
      page_next = byte_data[2:0]; // RL20
    end
  end
  // Page flop
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      page_reg <= 3'h0;
    end else begin
      page_reg <= page_next;
    end
  end

  // One register per mode flag, all zero after reset
  for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
    logic bit_reg, bit_next;
    always_comb begin
      bit_next = bit_reg;
      if (flag_hit[i]) begin
        bit_next = flag_bit[i]; // RL6 RL8 RL9 RL17 RL21
      end
    end
    // Flag flop; held through sleep like every setting
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        bit_reg <= 1'b0; // RL9 RL17
      end else begin
        bit_reg <= bit_next;
      end
    end
    assign flag_reg[i] = bit_reg;
    assign flag_next[i] = bit_next;
  end

  // Column: each access below the last column bumps it, regardless of remap
  always_comb begin
    col_next = col_reg;
    if (ram_access && (col_reg != `COL_LAST)) begin
      col_next = col_reg + 8'h01; // RL7
    end
    // A column command in the same cycle wins over the bump
    if (hit_col_low) begin
      col_next = {col_reg[7:4], byte_data[3:0]};
    end else if (hit_col_high) begin
      col_next = {byte_data[3:0], col_reg[3:0]};
    end
  end
  // Stops at the last column; access goes on during sleep
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      col_reg <= 8'h00;
    end else begin
      col_reg <= col_next; // RL19
    end
  end

  // Sleep follows the next display flag, so it never lags it
  always_comb begin
    sleep_next = !flag_next[FLAG_DISPLAY]; // RL16 RL18
  end
  // Panel is asleep after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sleep_reg <= 1'b1;
    end else begin
      sleep_reg <= sleep_next;
    end
  end

  // Supply source: converter only once the display is on
  always_comb begin
    dcdc_run_next = flag_next[FLAG_DISPLAY] && dcdc_next; // RL14
    ext_supply_next = flag_next[FLAG_DISPLAY] && !dcdc_next; // RL16
  end
  // Neither supply runs while asleep
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dcdc_run_reg <= 1'b0;
      ext_supply_reg <= 1'b0;
    end else begin
      dcdc_run_reg <= dcdc_run_next;
      ext_supply_reg <= ext_supply_next;
    end
  end

  // Forced-on wins over inversion; RAM untouched
  always_comb begin
    force_next = flag_next[FLAG_ENTIRE]; // RL10
  end
  // Normal display after reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      force_reg <= 1'b0;
    end else begin
      force_reg <= force_next;
    end
  end

  // Setting outputs straight from flip-flops
  assign contrast = contrast_reg;
  assign segment_reverse = flag_reg[FLAG_REMAP];
  assign entire_on = flag_reg[FLAG_ENTIRE];
  assign invert = flag_reg[FLAG_INVERT];
  assign mux_ratio = mux_ratio_reg; // RL12
  assign dcdc_enable = dcdc_reg;
  assign display_on = flag_reg[FLAG_DISPLAY];
  assign page_address = page_reg;
  assign column_address = col_reg;
  assign com_reverse = flag_reg[FLAG_SCAN];
  // Armed flag is a decode of the phase flop
  assign contrast_armed = (phase_reg == PH_CONTRAST); // RL1
  // Driver state is a flag only; no real tristate here
  assign sleep = sleep_reg; // RL16
  assign oscillator_run = !sleep_reg; // RL18
  assign outputs_hiz = sleep_reg; // RL18
  assign dcdc_run = dcdc_run_reg; // RL14
  assign external_supply = ext_supply_reg; // RL16
  assign force_pixels = force_reg; // RL10
endmodule

// ---- oled_host_model.sv ----
`timescale 1ns/1ps
module oled_host_model (
  input wire logic clk_sys,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic command_data_select,
  output logic ram_access
);
  // Quiet lines at time zero
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    command_data_select = 1'b0;
    ram_access = 1'b0;
  end
  // Entered just after an edge; defined codes only, display off before converter setup
  task put(input logic [7:0] b, input logic sel);
    byte_valid = 1'b1;
    byte_data = b;
    command_data_select = sel;
    @(posedge clk_sys);
    #1;
  endtask
  // Inverted stale byte so an old value is never read as fresh
  task idle;
    byte_valid = 1'b0;
    ram_access = 1'b0;
    byte_data = ~byte_data;
    @(posedge clk_sys);
    #1;
  endtask
  task bump;
    ram_access = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask
endmodule

// ---- oled_panel_command_decoder_chk.sv ----
`timescale 1ns/1ps
module oled_cmd_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic byte_valid,
  input wire logic command_data_select,
  input wire logic [7:0] byte_data,
  input wire logic [7:0] contrast,
  input wire logic contrast_armed,
  input wire logic segment_reverse,
  input wire logic entire_on,
  input wire logic dcdc_enable,
  input wire logic display_on,
  input wire logic sleep,
  input wire logic dcdc_run,
  input wire logic force_pixels,
  input wire logic com_reverse
);
  logic cmd, pend_reg, pend_next;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Second byte of a two-byte command is a value, not a command
  assign cmd = byte_valid && !command_data_select;
  always_comb begin
    pend_next = pend_reg;
    if (cmd) pend_next = !pend_reg && (byte_data inside {8'h81, 8'ha8, 8'had});
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) pend_reg <= 1'b0;
    else pend_reg <= pend_next;
  end
  sequence s_arm;
    cmd && !pend_reg && byte_data == 8'h81;
  endsequence
  sequence s_value;
    cmd && contrast_armed;
  endsequence
  AST_ARM: assert property (s_arm |=> contrast_armed) else $error("not armed");
  AST_VAL: assert property (s_value |=> contrast == $past(byte_data) && !contrast_armed)
    else $error("contrast");
  AST_SLP: assert property (sleep == !display_on) else $error("sleep");
  AST_RUN: assert property (dcdc_run == (display_on && dcdc_enable)) else $error("run");
  AST_FRC: assert property (force_pixels == entire_on) else $error("force");
  AST_DSP: assert property (cmd && !pend_reg && byte_data[7:1] == 7'h57
    |=> display_on == $past(byte_data[0])) else $error("display");
  AST_SEG: assert property (cmd && !pend_reg && byte_data[7:1] == 7'h50
    |=> segment_reverse == $past(byte_data[0])) else $error("remap");
  AST_COM: assert property (cmd && !pend_reg && byte_data[7:4] == 4'hc
    |=> com_reverse == $past(byte_data[3])) else $error("scan");
  AST_DAT: assert property (byte_valid && command_data_select
    |=> $stable(contrast) && $stable(display_on)) else $error("data byte");
endmodule
bind oled_panel_command_decoder oled_cmd_chk chk (.*);

// ---- oled_panel_command_decoder_tb.sv ----
`timescale 1ns/1ps
module oled_panel_command_decoder_tb import oled_cmd_pkg::*;;
  logic clk_sys, reset, byte_valid, command_data_select, ram_access, invert, dcdc_enable;
  logic contrast_armed, segment_reverse, entire_on, display_on, sleep, dcdc_run;
  logic external_supply, oscillator_run, outputs_hiz, force_pixels, com_reverse;
  logic [7:0] byte_data, contrast, column_address;
  logic [6:0] mux_ratio;
  logic [2:0] page_address;
  logic [7:0] cv[4] = '{8'h00, 8'hff, 8'ha5, 8'h80};
  int mismatches, n_compared, test_no;
  oled_host_model h (.*);
  oled_panel_command_decoder dut (.*);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Back-to-back command bytes, then one quiet cycle
  task cmds(input logic [7:0] q[$]);
    foreach (q[i]) h.put(q[i], 1'b0);
    h.idle();
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Whole run is about fifty cycles
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
  initial begin
    reset = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    chk("contrast", 8'h80, contrast);
    chk("mux", 8'h40, mux_ratio);
    chk("sleep", 8'h01, sleep);
    foreach (cv[i]) begin
      cmds({8'h81, cv[i]});
      chk("contrast", cv[i], contrast);
      chk("force", 8'h00, force_pixels);
      chk("armed", 8'h00, contrast_armed);
    end
    $display("test 1 done");
    cmds({8'ha8, 8'hc5});
    chk("mux", 8'h06, mux_ratio);
    cmds({8'ha1, 8'ha5, 8'haf});
    chk("remap", 8'h01, segment_reverse);
    chk("force", 8'h01, force_pixels);
    chk("entire", 8'h01, entire_on);
    chk("run", 8'h01, dcdc_run);
    cmds({8'hae, 8'had, 8'h8a, 8'haf});
    chk("external", 8'h01, external_supply);
    chk("converter", 8'h00, dcdc_enable);
    chk("run", 8'h00, dcdc_run);
    $display("test 2 done");
    cmds({8'hb5, 8'hc8});
    chk("page", 8'h05, page_address);
    chk("scan", 8'h01, com_reverse);
    h.put(8'hae, 1'b1);
    h.idle();
    chk("display", 8'h01, display_on);
    h.bump();
    h.bump();
    h.idle();
    chk("column", 8'h02, column_address);
    $display("test 3 done");
    h.put(8'h81, 1'b0);
    chk("armed", 8'h01, contrast_armed);
    h.put(8'hae, 1'b0);
    h.idle();
    chk("contrast", 8'hae, contrast);
    chk("display", 8'h01, display_on);
    cmds({8'ha7});
    chk("invert", 8'h01, invert);
    chk("force", 8'h01, force_pixels);
    cmds({8'ha4, 8'hae, 8'h02, 8'h18});
    chk("force", 8'h00, force_pixels);
    chk("hiz", 8'h01, outputs_hiz);
    chk("osc", 8'h00, oscillator_run);
    h.bump();
    h.bump();
    h.idle();
    chk("column", 8'h83, column_address);
    chk("contrast", 8'hae, contrast);
    $display("test 4 done");
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    chk("contrast", 8'h80, contrast);
    chk("column", 8'h00, column_address);
    chk("invert", 8'h00, invert);
    $display("test 5 done");
    close_out();
  end
endmodule
